// [agr_pkg.sv]
package agr_pkg;

   // ***********************************************************
   // sizes and field positions
   // ***********************************************************
   localparam int          CHANNELS   = 16;
   localparam int          DATA_W     = 11;
   localparam int          WORD_W     = 16;
   localparam int          FIFO_DEPTH = 4;
   localparam int          BUF_WORDS  = 17;
   localparam int          HDR_BIT    = 15;
   localparam int          SA_LSB     = 11;
   localparam logic [10:0] OVERFLOW_VAL = 11'h7ff;
   localparam logic [15:0] STATUS_RST   = 16'h0000;

   // ***********************************************************
   // dataway function and subaddress codes
   // ***********************************************************
   localparam logic [4:0] F_RD_STATUS = 5'h00;
   localparam logic [4:0] F_RD_DATA   = 5'h02;
   localparam logic [4:0] F_CLEAR     = 5'h09;
   localparam logic [4:0] F_WR_STATUS = 5'h10;
   localparam logic [4:0] F_TEST      = 5'h19;
   localparam logic [3:0] A_ZERO      = 4'h0;

   // ***********************************************************
   // timing
   // ***********************************************************
   localparam int          CLK_NS        = 4;
   localparam int          TEST_GATE_NS  = 100;
   localparam logic [7:0]  TEST_GATE_CYC =
      8'((TEST_GATE_NS + CLK_NS - 1) / CLK_NS);

   // ***********************************************************
   // types
   // ***********************************************************
   typedef struct packed {
      logic       overflow_suppress_en;
      logic       lam_en;
      logic       dataway_sequential_rd_en;
      logic       dataway_compress_en;
      logic       dataway_pedestal_sub_en;
      logic       fast_port_en;
      logic       fast_port_compress_en;
      logic       fast_port_pedestal_sub_en;
      logic [7:0] station_tag;
   } agr_status_s;

   typedef struct packed {
      logic        strb;
      logic        z;
      logic        c;
      logic        n;
      logic [4:0]  f;
      logic [3:0]  a;
      logic [15:0] w;
   } agr_cmd_s;

   typedef logic [15:0][10:0] agr_chan_t;

   typedef enum logic [3:0] {
      SQ_IDLE = 4'b0001,
      SQ_FAST = 4'b0010,
      SQ_DWAY = 4'b0100,
      SQ_DONE = 4'b1000
   } agr_seq_e;

endpackage

// [agr_fifo.sv]
`timescale 1ns/1ps
module agr_fifo #(
   parameter int W = 16,
   parameter int D = 4
) (
   input  wire logic         sys_clk,
   input  wire logic         resetn,
   input  wire logic         clr,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int PW = (D > 1) ? $clog2(D) : 1;

   logic [W-1:0]  mem [D];
   logic [PW-1:0] wr_ptr_r;
   logic [PW-1:0] rd_ptr_r;
   logic [PW:0]   cnt_r;
   logic          push;
   logic          pop;

   assign in_ready  = (cnt_r != (PW+1)'(D));
   assign out_valid = (cnt_r != '0);
   assign out_data  = mem[rd_ptr_r];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem[wr_ptr_r] <= in_data;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         cnt_r    <= '0;
      end else if (clr) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         cnt_r    <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == PW'(D-1)) ? '0 : wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= (rd_ptr_r == PW'(D-1)) ? '0 : rd_ptr_r + 1'b1;
         end
         cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
      end
   end
endmodule // agr_fifo

// [agr_gate_readout.sv]
`timescale 1ns/1ps
// Functional notes
// - F16 A0 writes status; F0 A0 reads back
// - status bit layout: options and station tag
// - uncompressed: 16 words, channels 0..15
// - compressed: header, station, count, tagged words
// - clear forces and holds busy at zero
// - clear from panel, Z, C, or F9 A0
// - clear holds converter clear flip-flop reset
// - ready: readout inhibited, gate accepted
// - gate from panel or F25 A0 one-shot
// - gate start releases clear, opens gates
// - gate trailing edge sets busy
// - busy: ignore gate, reject most functions
// - busy set fires digitization start
// - fast compress, all zero: no words
// - dataway compress, all zero: no readout, no LAM
module agr_gate_readout
   import agr_pkg::*;
(
   input  wire logic          sys_clk,
   input  wire logic          resetn,
   input  wire agr_cmd_s      cmd,
   output logic [15:0]        cmd_rdata,
   output logic               cmd_q,
   output logic               cmd_x,
   output logic               lam,
   input  wire logic          clear_in,
   input  wire logic          gate_in,
   input  wire logic          conv_done,
   input  wire agr_chan_t     chan_data,
   output logic               busy,
   output logic               conv_release,
   output logic               conv_gate,
   output logic               pedestal_en,
   output logic               digitize_start,
   output logic               fast_valid,
   input  wire logic          fast_ready,
   output logic [15:0]        fast_data
);

   // ***********************************************************
   // helpers
   // ***********************************************************
   function automatic logic keep_chan(input logic [10:0] v,
                                      input logic ofs);
      keep_chan = (v != 11'h000) && !(ofs && v == OVERFLOW_VAL);
   endfunction

   function automatic logic [4:0] kept_count(input agr_chan_t d,
                                             input logic ofs);
      logic [4:0] n;
      n = 5'h00;
      for (int i = 0; i < CHANNELS; i++) begin
         n = n + 5'(keep_chan(d[i], ofs));
      end
      kept_count = n;
   endfunction

   function automatic logic at_a0(input agr_cmd_s c, input logic [4:0] f);
      at_a0 = c.strb && c.n && c.f == f && c.a == A_ZERO;
   endfunction

   // ***********************************************************
   // state
   // ***********************************************************
   agr_status_s  st_r;
   agr_seq_e     seq_r;
   agr_chan_t    chan_r;
   logic         busy_r;
   logic         release_r;
   logic         conv_gate_r;
   logic         ped_r;
   logic         dig_r;
   logic         gate_q_r;
   logic [7:0]   test_cnt_r;
   logic [3:0]   ch_r;
   logic         hdr_pend_r;
   logic [15:0]  dw_buf [BUF_WORDS];
   logic [4:0]   dw_cnt_r;
   logic [4:0]   dw_rd_r;
   logic [15:0]  rdata_r;
   logic         q_r;
   logic         x_r;
   logic         lam_r;
   logic         fv_r;
   logic [15:0]  fd_r;

   // ***********************************************************
   // command decode
   // ***********************************************************
   logic clear_fn;
   logic wr_stat;
   logic rd_stat;
   logic rd_data;
   logic test_cmd;
   logic gate_any;
   logic gate_rise;
   logic gate_fall;

   assign clear_fn = clear_in | (cmd.strb & (cmd.z | cmd.c)) |
                     at_a0(cmd, F_CLEAR);
   // busy blocks all but readout and clear
   assign wr_stat  = at_a0(cmd, F_WR_STATUS) & ~busy_r;
   assign rd_stat  = at_a0(cmd, F_RD_STATUS) & ~busy_r;
   assign test_cmd = at_a0(cmd, F_TEST) & ~busy_r;
   assign rd_data  = cmd.strb & cmd.n & (cmd.f == F_RD_DATA);

   // panel gate or test one-shot, only while ready
   assign gate_any  = (gate_in | (test_cnt_r != 8'h00)) &
                      ~busy_r & ~clear_fn;
   assign gate_rise = gate_any & ~gate_q_r;
   assign gate_fall = gate_q_r & ~gate_any & ~clear_fn;

   // ***********************************************************
   // readout sequencer datapath
   // ***********************************************************
   logic [4:0]  kept;
   logic        skip_fast;
   logic        skip_dway;
   logic        run_fast;
   logic        run_dway;
   logic        pass_comp;
   logic        cur_keep;
   logic [15:0] cur_word;
   logic        emit;
   logic        sink_rdy;
   logic        adv;
   logic        fifo_in_ready;
   logic        fo_valid;
   logic [15:0] fo_data;
   logic        fo_ready;
   logic [4:0]  rd_idx;
   logic        avail;

   assign kept      = kept_count(chan_r, st_r.overflow_suppress_en);
   assign skip_fast = ~st_r.fast_port_en |
                      (st_r.fast_port_compress_en & kept == 5'h00);
   assign skip_dway = st_r.dataway_compress_en & kept == 5'h00;
   assign run_fast  = (seq_r == SQ_FAST) & ~skip_fast;
   assign run_dway  = (seq_r == SQ_DWAY) & ~skip_dway;
   assign pass_comp = (seq_r == SQ_FAST) ? st_r.fast_port_compress_en
                                         : st_r.dataway_compress_en;
   assign cur_keep  = ~pass_comp |
                      keep_chan(chan_r[ch_r], st_r.overflow_suppress_en);
   // header: count of 16 wraps to 0 in four bits
   assign cur_word  = hdr_pend_r ?
      {1'b1, kept[3:0], 3'b000, st_r.station_tag} :
      {1'b0, pass_comp ? ch_r : 4'h0, chan_r[ch_r]};
   assign emit      = (run_fast | run_dway) & (hdr_pend_r | cur_keep);
   assign sink_rdy  = run_fast ? fifo_in_ready : 1'b1;
   assign adv       = (run_fast | run_dway) & ~hdr_pend_r &
                      (~cur_keep | sink_rdy);

   assign rd_idx = st_r.dataway_sequential_rd_en ? dw_rd_r
                                                 : {1'b0, cmd.a};
   assign avail  = (seq_r == SQ_DONE) & (rd_idx < dw_cnt_r);
   assign fo_ready = ~fv_r | fast_ready;

   agr_fifo #(
      .W (WORD_W),
      .D (FIFO_DEPTH)
   ) u_fifo (
      .sys_clk   (sys_clk),
      .resetn    (resetn),
      .clr       (clear_fn),
      .in_valid  (emit & run_fast),
      .in_ready  (fifo_in_ready),
      .in_data   (cur_word),
      .out_valid (fo_valid),
      .out_ready (fo_ready),
      .out_data  (fo_data)
   );

   // ***********************************************************
   // status register
   // ***********************************************************
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         st_r <= agr_status_s'(STATUS_RST);
      end else if (wr_stat) begin
         st_r <= agr_status_s'(cmd.w);
      end
   end

   // ***********************************************************
   // clear, gate and busy control
   // ***********************************************************
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         busy_r      <= 1'b0;
         release_r   <= 1'b0;
         conv_gate_r <= 1'b0;
         ped_r       <= 1'b0;
         dig_r       <= 1'b0;
         gate_q_r    <= 1'b0;
      end else begin
         gate_q_r    <= gate_any;
         conv_gate_r <= gate_any;
         ped_r       <= gate_any;
         dig_r       <= gate_fall;
         if (clear_fn) begin
            busy_r    <= 1'b0;
            release_r <= 1'b0;
         end else begin
            if (gate_fall) begin
               busy_r <= 1'b1;
            end
            if (gate_rise) begin
               release_r <= 1'b1;
            end
         end
      end
   end

   // test one-shot; retrigger restarts the width
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         test_cnt_r <= 8'h00;
      end else if (clear_fn) begin
         test_cnt_r <= 8'h00;
      end else if (test_cmd) begin
         test_cnt_r <= TEST_GATE_CYC;
      end else if (test_cnt_r != 8'h00) begin
         test_cnt_r <= test_cnt_r - 8'h01;
      end
   end

   // ***********************************************************
   // readout sequencer
   // ***********************************************************
   always_ff @(posedge sys_clk) begin
      if (conv_done && busy_r && seq_r == SQ_IDLE) begin
         chan_r <= chan_data;
      end
      if (emit && run_dway) begin
         dw_buf[dw_cnt_r] <= cur_word;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         seq_r      <= SQ_IDLE;
         ch_r       <= 4'h0;
         hdr_pend_r <= 1'b0;
         dw_cnt_r   <= 5'h00;
      end else if (clear_fn) begin
         seq_r      <= SQ_IDLE;
         ch_r       <= 4'h0;
         hdr_pend_r <= 1'b0;
         dw_cnt_r   <= 5'h00;
      end else begin
         if (emit && sink_rdy) begin
            hdr_pend_r <= 1'b0;
         end
         if (emit && run_dway) begin
            dw_cnt_r <= dw_cnt_r + 5'h01;
         end
         if (adv) begin
            ch_r <= ch_r + 4'h1;
         end
         case (seq_r)
            SQ_IDLE: begin
               // readout held off until busy and converted
               if (conv_done && busy_r) begin
                  seq_r      <= SQ_FAST;
                  ch_r       <= 4'h0;
                  hdr_pend_r <= st_r.fast_port_compress_en;
               end
            end
            SQ_FAST: begin
               if (skip_fast || (adv && ch_r == 4'hf)) begin
                  seq_r      <= SQ_DWAY;
                  ch_r       <= 4'h0;
                  hdr_pend_r <= st_r.dataway_compress_en;
               end
            end
            SQ_DWAY: begin
               if (skip_dway || (adv && ch_r == 4'hf)) begin
                  seq_r <= SQ_DONE;
               end
            end
            SQ_DONE: begin
               seq_r <= SQ_DONE;
            end
            default: begin
               seq_r <= SQ_IDLE;
            end
         endcase
      end
   end

   // ***********************************************************
   // dataway responses and LAM
   // ***********************************************************
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rdata_r <= 16'h0000;
         q_r     <= 1'b0;
         x_r     <= 1'b0;
         dw_rd_r <= 5'h00;
         lam_r   <= 1'b0;
      end else begin
         x_r <= 1'b0;
         q_r <= 1'b0;
         if (clear_fn) begin
            dw_rd_r <= 5'h00;
         end else if (rd_data && avail &&
                      st_r.dataway_sequential_rd_en) begin
            dw_rd_r <= dw_rd_r + 5'h01;
         end
         if (rd_stat) begin
            rdata_r <= st_r;
            x_r     <= 1'b1;
            q_r     <= 1'b1;
         end else if (rd_data) begin
            rdata_r <= avail ? dw_buf[rd_idx] : 16'h0000;
            x_r     <= 1'b1;
            q_r     <= avail;
         end else if (wr_stat || test_cmd ||
                      at_a0(cmd, F_CLEAR)) begin
            x_r <= 1'b1;
            q_r <= 1'b1;
         end
         // no words kept means no request
         lam_r <= st_r.lam_en & st_r.dataway_sequential_rd_en &
                  (seq_r == SQ_DONE) & (dw_rd_r < dw_cnt_r) &
                  ~clear_fn;
      end
   end

   // ***********************************************************
   // fast port output stage
   // ***********************************************************
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         fv_r <= 1'b0;
         fd_r <= 16'h0000;
      end else if (clear_fn) begin
         fv_r <= 1'b0;
      end else if (fo_ready) begin
         fv_r <= fo_valid;
         fd_r <= fo_data;
      end
   end

   assign cmd_rdata      = rdata_r;
   assign cmd_q          = q_r;
   assign cmd_x          = x_r;
   assign lam            = lam_r;
   assign busy           = busy_r;
   assign conv_release   = release_r;
   assign conv_gate      = conv_gate_r;
   assign pedestal_en    = ped_r;
   assign digitize_start = dig_r;
   assign fast_valid     = fv_r;
   assign fast_data      = fd_r;

endmodule // agr_gate_readout

// [agr_gate_readout_checker.sv]
`timescale 1ns/1ps
module agr_gate_readout_checker
   import agr_pkg::*;
(
   input wire logic        sys_clk,
   input wire logic        resetn,
   input wire agr_cmd_s    cmd,
   input wire logic        cmd_x,
   input wire logic        cmd_q,
   input wire logic        clear_in,
   input wire logic        gate_in,
   input wire logic        busy,
   input wire logic        conv_release,
   input wire logic        conv_gate,
   input wire logic        pedestal_en,
   input wire logic        digitize_start,
   input wire logic        fast_valid,
   input wire logic        fast_ready,
   input wire logic [15:0] fast_data
);
   logic on;
   logic clr;
   // ****************
   // any clear source
   // ****************
   assign on  = cmd.strb && cmd.n;
   assign clr = clear_in || (cmd.strb && (cmd.z || cmd.c)) ||
                (on && cmd.f == F_CLEAR && cmd.a == A_ZERO);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   property p_clr;
      clr |=> !busy && !conv_release;
   endproperty
   a_clr: assert property (p_clr)
      else $error("clear did not reset busy");
   property p_gate_on;
      $rose(gate_in) && !busy && !clr |=>
         conv_gate && pedestal_en && conv_release;
   endproperty
   a_gate_on: assert property (p_gate_on)
      else $error("gate start not seen");
   property p_busy_set;
      $fell(conv_gate) && !$past(clr) |-> busy && digitize_start;
   endproperty
   a_busy_set: assert property (p_busy_set)
      else $error("gate end did not set busy");
   property p_start_once;
      digitize_start |=> !digitize_start;
   endproperty
   a_start_once: assert property (p_start_once)
      else $error("start pulse too long");
   property p_busy_keep;
      busy && !clr |=> busy && !conv_gate;
   endproperty
   a_busy_keep: assert property (p_busy_keep)
      else $error("busy lost or gate taken");
   property p_busy_rej;
      busy && on && cmd.f == F_WR_STATUS && !clr |=> !cmd_x && !cmd_q;
   endproperty
   a_busy_rej: assert property (p_busy_rej)
      else $error("write taken while busy");
   property p_rd_ans;
      on && cmd.f == F_RD_STATUS && cmd.a == A_ZERO && !busy |=>
         cmd_x && cmd_q;
   endproperty
   a_rd_ans: assert property (p_rd_ans)
      else $error("status read not answered");
   property p_ready_idle;
      !busy |-> !fast_valid;
   endproperty
   a_ready_idle: assert property (p_ready_idle)
      else $error("readout while ready");
   property p_fast_hold;
      fast_valid && !fast_ready && !clr |=>
         fast_valid && $stable(fast_data);
   endproperty
   a_fast_hold: assert property (p_fast_hold)
      else $error("fast word dropped");
endmodule // agr_gate_readout_checker

bind agr_gate_readout agr_gate_readout_checker agr_gate_readout_checker_i (
   .sys_clk, .resetn, .cmd, .cmd_x, .cmd_q, .clear_in, .gate_in, .busy,
   .conv_release, .conv_gate, .pedestal_en, .digitize_start, .fast_valid,
   .fast_ready, .fast_data);

// [agr_fast_sink.sv]
`timescale 1ns/1ps
module agr_fast_sink (
   input  wire logic        sys_clk,
   input  wire logic        resetn,
   input  wire logic        stall,
   input  wire logic        fast_valid,
   output logic             fast_ready,
   input  wire logic [15:0] fast_data
);
   logic [15:0] words[$];
   // ****************
   // ready lags stall a cycle, like a slow driver
   // ****************
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn)
         fast_ready <= 1'h0;
      else
         fast_ready <= !stall;
   end
   always @(posedge sys_clk) begin
      if (resetn && fast_valid && fast_ready)
         words.push_back(fast_data);
   end
endmodule // agr_fast_sink

// [agr_gate_readout_tb.sv]
`timescale 1ns/1ps
module agr_gate_readout_tb;
   import agr_pkg::*;
   logic        sys_clk;
   logic        resetn;
   agr_cmd_s    cmd;
   logic [15:0] cmd_rdata;
   logic        cmd_q;
   logic        cmd_x;
   logic        lam;
   logic        clear_in;
   logic        gate_in;
   logic        conv_done;
   agr_chan_t   chan_data;
   logic        busy;
   logic        conv_release;
   logic        conv_gate;
   logic        pedestal_en;
   logic        digitize_start;
   logic        fast_valid;
   logic        fast_ready;
   logic [15:0] fast_data;
   logic        stall;
   int          n_fail;
   int          cmp_count;
   logic [15:0] exp_q[$];

   agr_gate_readout agr_gate_readout_i (.sys_clk, .resetn, .cmd, .cmd_rdata,
      .cmd_q, .cmd_x, .lam, .clear_in, .gate_in, .conv_done, .chan_data,
      .busy, .conv_release, .conv_gate, .pedestal_en, .digitize_start,
      .fast_valid, .fast_ready, .fast_data);
   agr_fast_sink agr_fast_sink_i (.sys_clk, .resetn, .stall, .fast_valid,
      .fast_ready, .fast_data);

   always #2 sys_clk = ~sys_clk;

   // ****************
   // helpers
   // ****************
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // x and q stand one cycle only: sample them right after the strobe edge
   task automatic cyc(input logic [4:0] f, input logic [15:0] w);
      @(posedge sys_clk);
      cmd <= '{strb:1'h1, z:1'h0, c:1'h0, n:1'h1, f:f, a:4'h0, w:w};
      @(posedge sys_clk);
      cmd.strb <= 1'h0;
      #1;
   endtask
   task automatic zc(input logic z, input logic c);
      @(posedge sys_clk);
      cmd <= '{strb:1'h1, z:z, c:c, n:1'h0, f:5'h00, a:4'h0, w:16'h0000};
      @(posedge sys_clk);
      cmd.strb <= 1'h0;
      @(posedge sys_clk);
      #1;
      agr_fast_sink_i.words.delete();
   endtask
   task automatic clr_pan;
      @(posedge sys_clk);
      clear_in <= 1'h1;
      repeat (3) @(posedge sys_clk);
      #1;
      chk(16'({busy, conv_release}), 16'h0000);
      @(posedge sys_clk);
      clear_in <= 1'h0;
      agr_fast_sink_i.words.delete();
   endtask
   task automatic mk_exp(input logic cm, input logic ofs,
                         input logic [7:0] st);
      logic [3:0] k;
      exp_q.delete();
      for (int i = 0; i < 16; i++) begin
         if (!cm)
            exp_q.push_back({5'h00, chan_data[i]});
         else if (chan_data[i] != 11'h000 &&
                  !(ofs && chan_data[i] == OVERFLOW_VAL))
            exp_q.push_back({1'h0, 4'(i), chan_data[i]});
      end
      k = 4'(exp_q.size());
      if (cm && exp_q.size() > 0)
         exp_q.push_front({1'h1, k, 3'h0, st});
   endtask
   // gate by panel or test command, then hand over a conversion
   task automatic run_ev(input logic [15:0] st, input logic tst);
      @(posedge sys_clk);
      stall <= 1'h1;
      cyc(F_WR_STATUS, st);
      chk(16'({cmd_x, cmd_q}), 16'h0003);
      if (tst) begin
         cyc(F_TEST, 16'h0000);
      end else begin
         @(posedge sys_clk);
         gate_in <= 1'h1;
         @(posedge sys_clk);
         #1;
         chk(16'({conv_gate, pedestal_en, conv_release}), 16'h0007);
         repeat (3) @(posedge sys_clk);
         gate_in <= 1'h0;
         @(posedge sys_clk);
         #1;
         chk(16'({busy, digitize_start}), 16'h0003);
      end
      for (int k = 0; k < 60 && busy !== 1'h1; k++)
         @(posedge sys_clk);
      chk(16'(busy), 16'h0001);
      @(posedge sys_clk);
      conv_done <= 1'h1;
      @(posedge sys_clk);
      conv_done <= 1'h0;
   endtask
   // fast port under stall, then sequential dataway reads
   task automatic do_read(input logic [15:0] st, input logic tst);
      run_ev(st, tst);
      mk_exp(st[9], st[15], st[7:0]);
      repeat (20) @(posedge sys_clk);
      stall <= 1'h0;
      for (int k = 0; k < 400 &&
           agr_fast_sink_i.words.size() < exp_q.size(); k++)
         @(posedge sys_clk);
      chk(16'(agr_fast_sink_i.words.size()), 16'(exp_q.size()));
      foreach (exp_q[i])
         chk(agr_fast_sink_i.words[i], exp_q[i]);
      for (int k = 0; k < 200 && lam !== 1'h1; k++)
         @(posedge sys_clk);
      #1;
      chk(16'(lam), 16'h0001);
      foreach (exp_q[i]) begin
         cyc(F_RD_DATA, 16'h0000);
         chk(cmd_rdata, exp_q[i]);
      end
      @(posedge sys_clk);
      #1;
      chk(16'(lam), 16'h0000);
   endtask

   // ****************
   // scenarios
   // ****************
   task automatic t_status;
      cyc(F_WR_STATUS, 16'ha5c3);
      cyc(F_RD_STATUS, 16'h0000);
      chk(cmd_rdata, 16'ha5c3);
      cyc(F_WR_STATUS, 16'h5a3c);
      cyc(F_RD_STATUS, 16'h0000);
      chk(cmd_rdata, 16'h5a3c);
   endtask
   task automatic t_plain;
      @(posedge sys_clk);
      for (int i = 0; i < 16; i++)
         chan_data[i] <= (i == 7) ? OVERFLOW_VAL : 11'(i * 97 + 5);
      do_read(16'h645a, 1'h0);
      clr_pan;
   endtask
   // same pattern compressed: all 16 kept, count wraps to 0
   task automatic t_full;
      do_read(16'h7611, 1'h0);
      cyc(F_CLEAR, 16'h0000);
      chk(16'(busy), 16'h0000);
      agr_fast_sink_i.words.delete();
   endtask
   task automatic t_ofs;
      @(posedge sys_clk);
      for (int i = 0; i < 16; i++)
         chan_data[i] <= (i == 3) ? OVERFLOW_VAL : (i == 5) ? 11'h00c :
                         (i == 15) ? 11'h077f : 11'h000;
      do_read(16'hf63c, 1'h1);
      zc(1'h1, 1'h0);
      chk(16'(busy), 16'h0000);
   endtask
   task automatic t_zero;
      @(posedge sys_clk);
      chan_data <= '0;
      run_ev(16'h7612, 1'h0);
      stall <= 1'h0;
      repeat (100) @(posedge sys_clk);
      chk(16'(agr_fast_sink_i.words.size()), 16'h0000);
      chk(16'(lam), 16'h0000);
      zc(1'h0, 1'h1);
      chk(16'(busy), 16'h0000);
   endtask
   task automatic t_busy;
      run_ev(16'h0400, 1'h0);
      gate_in <= 1'h1;
      repeat (3) @(posedge sys_clk);
      #1;
      chk(16'(conv_gate), 16'h0000);
      @(posedge sys_clk);
      gate_in <= 1'h0;
      cyc(F_WR_STATUS, 16'hffff);
      chk(16'({cmd_x, cmd_q}), 16'h0000);
      cyc(F_RD_STATUS, 16'h0000);
      chk(16'({cmd_x, cmd_q}), 16'h0000);
      clr_pan;
      cyc(F_RD_STATUS, 16'h0000);
      chk(cmd_rdata, 16'h0400);
   endtask

   task automatic close_out;
      if (n_fail == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial begin
      sys_clk = 1'h0;
      resetn = 1'h0;
      cmd = '0;
      clear_in = 1'h0;
      gate_in = 1'h0;
      conv_done = 1'h0;
      chan_data = '0;
      stall = 1'h1;
      n_fail = 0;
      cmp_count = 0;
      repeat (16) @(posedge sys_clk);
      resetn <= 1'h1;
      t_status;
      t_plain;
      t_full;
      t_ofs;
      t_zero;
      t_busy;
      close_out;
   end
   // about forty times the expected run length
   initial begin
      #80000;
      n_fail++;
      close_out;
   end
endmodule // agr_gate_readout_tb
